// file: logic/sla_pkg.sv
// Shared constants of the sequencing logic array: sizes, register map and bit positions
package sla_pkg;
  localparam int NUM_CELLS  = 9;
  localparam int NUM_SUPPLY = 7;
  localparam int NUM_LIN    = 4;
  localparam int NUM_PEER   = 8;
  localparam int NUM_IN     = 21;
  localparam int NUM_CFG    = 14;
  localparam int SYNC_W     = 13;

  // Byte offsets inside one cell's 16-byte window, cell n sits at (n-1) << 4
  localparam logic [3:0] OFS_PEER_INV_A   = 4'h0;
  localparam logic [3:0] OFS_PEER_IGN_A   = 4'h1;
  localparam logic [3:0] OFS_SUPPLY_INV_A = 4'h2;
  localparam logic [3:0] OFS_SUPPLY_IGN_A = 4'h3;
  localparam logic [3:0] OFS_LIN_A        = 4'h4;
  localparam logic [3:0] OFS_LIN_B        = 4'h5;
  localparam logic [3:0] OFS_WDT          = 4'h6;
  localparam logic [3:0] OFS_ENABLE       = 4'h7;
  localparam logic [3:0] OFS_PEER_INV_B   = 4'h8;
  localparam logic [3:0] OFS_PEER_IGN_B   = 4'h9;
  localparam logic [3:0] OFS_SUPPLY_INV_B = 4'hA;
  localparam logic [3:0] OFS_SUPPLY_IGN_B = 4'hB;
  localparam logic [3:0] OFS_RISE_DLY     = 4'hC;
  localparam logic [3:0] OFS_FALL_DLY     = 4'hD;
  localparam logic [3:0] OFS_STATUS       = 4'hE;

  localparam logic [7:0] CFG_RESET = 8'h00;

  // Positions in the 21-bit condition vector
  localparam int IN_SUPPLY_LSB  = 0;
  localparam int IN_LIN_LSB     = 7;
  localparam int IN_WDT_LATCHED = 11;
  localparam int IN_WDT_PULSED  = 12;
  localparam int IN_PEER_LSB    = 13;

  // Field positions
  localparam int LIN_IGN_LSB    = 4;
  localparam int WDT_LAT_INV    = 0;
  localparam int WDT_LAT_IGN    = 1;
  localparam int WDT_PUL_INV    = 2;
  localparam int WDT_PUL_IGN    = 3;
  localparam int WDT_B_LSB      = 4;
  localparam int EN_A_BIT       = 0;
  localparam int EN_B_BIT       = 1;
  localparam int OUT_INV_BIT    = 2;
  localparam int STAT_RESULT    = 0;
  localparam int STAT_DELAYED   = 1;
  localparam int STAT_OUTPUT    = 2;
endpackage

// file: logic/sla_cell.sv
// One macrocell: two conditioned product terms, enable, edge delay unit and output inversion
`timescale 1ns/1ps
module sla_cell (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [sla_pkg::NUM_IN-1:0] cond_in,
  input  wire logic [sla_pkg::NUM_IN-1:0] inv_a,
  input  wire logic [sla_pkg::NUM_IN-1:0] ign_a,
  input  wire logic [sla_pkg::NUM_IN-1:0] inv_b,
  input  wire logic [sla_pkg::NUM_IN-1:0] ign_b,
  input  wire logic [1:0]                en,
  input  wire logic                      out_inv,
  input  wire logic [7:0]                rise_dly,
  input  wire logic [7:0]                fall_dly,
  output logic                           cell_result,
  output logic                           delayed,
  output logic                           seq_out
);
  logic       term_a;
  logic       term_b;
  logic [7:0] cnt;
  logic [7:0] dly_sel;
  logic       at_limit;
  logic [7:0] next_cnt;
  logic       next_delayed;
  logic       next_seq_out;

  always_comb begin
    term_a       = &((cond_in ^ inv_a) | ign_a);
    term_b       = &((cond_in ^ inv_b) | ign_b);
    cell_result  = (en[sla_pkg::EN_A_BIT] & term_a) | (en[sla_pkg::EN_B_BIT] & term_b);
    dly_sel      = cell_result ? rise_dly : fall_dly;
    at_limit     = (cnt >= dly_sel);
    next_cnt     = 8'h00;
    next_delayed = delayed;
    // A pending edge must see the new level stable for delay+1 cycles; a bounce restarts it
    if (cell_result != delayed) begin
      if (at_limit) begin
        next_delayed = cell_result;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
    next_seq_out = delayed ^ out_inv;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt     <= 8'h00;
      delayed <= 1'b0;
      seq_out <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      delayed <= next_delayed;
      seq_out <= next_seq_out;
    end
  end

  property p_ignore_all;
    @(posedge clk) disable iff (rst)
      (ign_a == {sla_pkg::NUM_IN{1'b1}} && en == 2'h1) |-> cell_result;
  endproperty
  a_ignore_all: assert property (p_ignore_all) else $error("ignored inputs did not give 1");

  property p_invert_all;
    @(posedge clk) disable iff (rst)
      (ign_a == '0 && inv_a == {sla_pkg::NUM_IN{1'b1}} && en == 2'h1)
        |-> (cell_result == ~|cond_in);
  endproperty
  a_invert_all: assert property (p_invert_all) else $error("inversion of inputs is wrong");

  property p_none_enabled;
    @(posedge clk) disable iff (rst) (en == 2'h0) |-> !cell_result;
  endproperty
  a_none_enabled: assert property (p_none_enabled) else $error("disabled cell asserted");

  property p_only_a;
    @(posedge clk) disable iff (rst) (en == 2'h1) |-> (cell_result == term_a);
  endproperty
  a_only_a: assert property (p_only_a) else $error("function A alone not selected");

  property p_either;
    @(posedge clk) disable iff (rst) (en == 2'h3) |-> (cell_result == (term_a | term_b));
  endproperty
  a_either: assert property (p_either) else $error("A or B does not combine");

  property p_rise_two;
    @(posedge clk) disable iff (rst)
      (!delayed && cnt == 8'h00 && cell_result && rise_dly == 8'h02)
        ##0 (cell_result && rise_dly == 8'h02)[*3] |=> delayed;
  endproperty
  a_rise_two: assert property (p_rise_two) else $error("rise delay of 2 not three cycles");

  property p_change_at_limit;
    @(posedge clk) disable iff (rst) $changed(delayed) |-> $past(at_limit);
  endproperty
  a_change_at_limit: assert property (p_change_at_limit) else $error("edge passed early");

  property p_out_invert;
    @(posedge clk) disable iff (rst)
      $stable(out_inv) ##1 ($stable(out_inv) && $stable(delayed))
        |-> (seq_out == (delayed ^ out_inv));
  endproperty
  a_out_invert: assert property (p_out_invert) else $error("output inversion wrong");

  c_rise:   cover property (@(posedge clk) disable iff (rst) $rose(delayed));
  c_fall:   cover property (@(posedge clk) disable iff (rst) $fell(delayed));
  c_both:   cover property (@(posedge clk) disable iff (rst) en == 2'h3 && term_b && !term_a);
endmodule

// file: logic/sla_array.sv
// Sequencing logic array: input synchronisers, configuration latches and nine macrocells
`timescale 1ns/1ps
// How it works
// - Nine macrocells, each alone driving one sequenced output channel.
// - Two AND terms per cell, A and B, each can assert independently.
// - Each term sees 7 supply faults, 4 inputs, two watchdog bits, 8 peers.
// - A cell's own delayed output never enters its own terms.
// - All 21 inputs wired to both terms; selection only by configuration bits.
// - Each input XORed with its invert bit before the AND.
// - After inversion, each input ORed with its ignore bit, forcing 1.
// - Every function of every cell has its own invert and ignore bits.
// - Per-cell enable picks A, B or both for the cell result.
// - Cell result passes through separate rising and falling delays.
// - Delayed output optionally inverted before driving the channel.
// - Configuration latched locally, cleared to zero at reset, rewritable over the parallel byte register port.
// - Supply fault inputs are 1 on fault, 0 when in tolerance.
// - All invert and ignore bytes reset to zero.
module sla_array (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic [sla_pkg::NUM_SUPPLY-1:0] supply_fault,
  input  wire logic [sla_pkg::NUM_LIN-1:0]    general_logic_input,
  input  wire logic                           watchdog_latched,
  input  wire logic                           watchdog_pulsed,
  input  wire logic                           reg_wr_en,
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [7:0]                     reg_wr_data,
  output logic      [7:0]                     reg_rd_data,
  output logic      [sla_pkg::NUM_CELLS-1:0]  sequenced_output
);
  localparam int NC = sla_pkg::NUM_CELLS;
  localparam int NI = sla_pkg::NUM_IN;

  logic [sla_pkg::SYNC_W-1:0] pin_raw;
  logic [sla_pkg::SYNC_W-1:0] sync1;
  logic [sla_pkg::SYNC_W-1:0] sync2;
  logic [sla_pkg::SYNC_W-1:0] sync3;
  logic [sla_pkg::SYNC_W-1:0] pin_flt;
  logic [sla_pkg::SYNC_W-1:0] next_pin_flt;

  logic [7:0] cfg      [NC][sla_pkg::NUM_CFG];
  logic [7:0] next_cfg [NC][sla_pkg::NUM_CFG];
  logic [7:0] next_rd_data;

  logic [NC-1:0] cell_result;
  logic [NC-1:0] delayed;
  logic [NC-1:0] seq_out;

  assign pin_raw = {watchdog_pulsed, watchdog_latched, general_logic_input, supply_fault};

  // A pin level is accepted only once two late stages agree, so one metastable sample is not seen
  always_comb begin
    next_pin_flt = pin_flt;
    for (int i = 0; i < sla_pkg::SYNC_W; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_pin_flt[i] = sync3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1   <= '0;
      sync2   <= '0;
      sync3   <= '0;
      pin_flt <= '0;
    end else begin
      sync1   <= pin_raw;
      sync2   <= sync1;
      sync3   <= sync2;
      pin_flt <= next_pin_flt;
    end
  end

  // Configuration latches; cell n occupies addresses (n-1)*16 .. (n-1)*16+13
  // Status byte is read only; a write to it is dropped like any unmapped byte
  always_comb begin
    next_cfg = cfg;
    if (reg_wr_en && reg_addr[7:4] < 4'(NC) && reg_addr[3:0] < 4'(sla_pkg::NUM_CFG)) begin
      next_cfg[reg_addr[7:4]][reg_addr[3:0]] = reg_wr_data;
    end
    next_rd_data = 8'h00;
    if (reg_addr[7:4] < 4'(NC)) begin
      if (reg_addr[3:0] < 4'(sla_pkg::NUM_CFG)) begin
        next_rd_data = cfg[reg_addr[7:4]][reg_addr[3:0]];
      end else if (reg_addr[3:0] == sla_pkg::OFS_STATUS) begin
        next_rd_data[sla_pkg::STAT_RESULT]  = cell_result[reg_addr[7:4]];
        next_rd_data[sla_pkg::STAT_DELAYED] = delayed[reg_addr[7:4]];
        next_rd_data[sla_pkg::STAT_OUTPUT]  = seq_out[reg_addr[7:4]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < NC; c++) begin
        for (int r = 0; r < sla_pkg::NUM_CFG; r++) begin
          cfg[c][r] <= sla_pkg::CFG_RESET;
        end
      end
      reg_rd_data <= 8'h00;
    end else begin
      cfg         <= next_cfg;
      reg_rd_data <= next_rd_data;
    end
  end

  assign sequenced_output = seq_out;

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_cell
      logic [NI-1:0] cond_in;
      logic [NI-1:0] inv_a;
      logic [NI-1:0] ign_a;
      logic [NI-1:0] inv_b;
      logic [NI-1:0] ign_b;
      logic [7:0]    wdt;
      logic [7:0]    peers;

      // Peers in ascending cell order with this cell's own output left out
      always_comb begin
        peers = 8'h00;
        for (int k = 0; k < NC - 1; k++) begin
          peers[k] = (k < g) ? delayed[k] : delayed[k + 1];
        end
      end

      // Watchdog byte serves both functions: low nibble for A, high nibble for B
      assign wdt     = cfg[g][sla_pkg::OFS_WDT];
      assign cond_in = {peers, pin_flt};
      assign inv_a = {cfg[g][sla_pkg::OFS_PEER_INV_A],
                      wdt[sla_pkg::WDT_PUL_INV], wdt[sla_pkg::WDT_LAT_INV],
                      cfg[g][sla_pkg::OFS_LIN_A][3:0],
                      cfg[g][sla_pkg::OFS_SUPPLY_INV_A][6:0]};
      assign ign_a = {cfg[g][sla_pkg::OFS_PEER_IGN_A],
                      wdt[sla_pkg::WDT_PUL_IGN], wdt[sla_pkg::WDT_LAT_IGN],
                      cfg[g][sla_pkg::OFS_LIN_A][sla_pkg::LIN_IGN_LSB +: 4],
                      cfg[g][sla_pkg::OFS_SUPPLY_IGN_A][6:0]};
      assign inv_b = {cfg[g][sla_pkg::OFS_PEER_INV_B],
                      wdt[sla_pkg::WDT_B_LSB + sla_pkg::WDT_PUL_INV],
                      wdt[sla_pkg::WDT_B_LSB + sla_pkg::WDT_LAT_INV],
                      cfg[g][sla_pkg::OFS_LIN_B][3:0],
                      cfg[g][sla_pkg::OFS_SUPPLY_INV_B][6:0]};
      assign ign_b = {cfg[g][sla_pkg::OFS_PEER_IGN_B],
                      wdt[sla_pkg::WDT_B_LSB + sla_pkg::WDT_PUL_IGN],
                      wdt[sla_pkg::WDT_B_LSB + sla_pkg::WDT_LAT_IGN],
                      cfg[g][sla_pkg::OFS_LIN_B][sla_pkg::LIN_IGN_LSB +: 4],
                      cfg[g][sla_pkg::OFS_SUPPLY_IGN_B][6:0]};

      sla_cell u_cell (
        .clk         (clk),
        .rst         (rst),
        .cond_in     (cond_in),
        .inv_a       (inv_a),
        .ign_a       (ign_a),
        .inv_b       (inv_b),
        .ign_b       (ign_b),
        .en          (cfg[g][sla_pkg::OFS_ENABLE][1:0]),
        .out_inv     (cfg[g][sla_pkg::OFS_ENABLE][sla_pkg::OUT_INV_BIT]),
        .rise_dly    (cfg[g][sla_pkg::OFS_RISE_DLY]),
        .fall_dly    (cfg[g][sla_pkg::OFS_FALL_DLY]),
        .cell_result (cell_result[g]),
        .delayed     (delayed[g]),
        .seq_out     (seq_out[g])
      );
    end
  endgenerate

  property p_write_lands;
    @(posedge clk) disable iff (rst)
      (reg_wr_en && reg_addr == 8'h01) |=> (cfg[0][1] == $past(reg_wr_data));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not latched");

  property p_reset_zero;
    @(posedge clk) disable iff (rst)
      $fell(rst) |-> (cfg[0][0] == 8'h00 && cfg[8][11] == 8'h00 && cfg[4][7] == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("config not zero after reset");

  property p_readback;
    @(posedge clk) disable iff (rst)
      (reg_wr_en && reg_addr == 8'h10) ##1 (!reg_wr_en && reg_addr == 8'h10)
        |=> (reg_rd_data == $past(reg_wr_data, 2));
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  // Routing and map checks; the term logic itself is checked inside each cell
  property p_peer_first;
    @(posedge clk) disable iff (rst)
      (g_cell[0].peers == delayed[8:1]) && (g_cell[8].peers == delayed[7:0]);
  endproperty
  a_peer_first: assert property (p_peer_first) else $error("own output fed back");

  property p_peer_mid;
    @(posedge clk) disable iff (rst) g_cell[4].peers == {delayed[8:5], delayed[3:0]};
  endproperty
  a_peer_mid: assert property (p_peer_mid) else $error("peer order wrong at cell 5");

  property p_sync_agree;
    @(posedge clk) disable iff (rst) (sync2 == sync3) |=> (pin_flt == $past(sync3));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("agreed pin level not taken");

  property p_status_read;
    @(posedge clk) disable iff (rst)
      (reg_addr == 8'h0E) |=> (reg_rd_data == {5'h00, $past(seq_out[0]), $past(delayed[0]),
                                               $past(cell_result[0])});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status byte wrong");

  property p_unmapped_read;
    @(posedge clk) disable iff (rst)
      (reg_addr[7:4] > 4'h8 || reg_addr[3:0] == 4'hF) |=> (reg_rd_data == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped byte not zero");

  c_out0: cover property (@(posedge clk) disable iff (rst) $rose(sequenced_output[0]));
  c_peer: cover property (@(posedge clk) disable iff (rst) delayed[0] && cell_result[1]);
endmodule

// file: dv/sla_far_side.sv
// Far-side model: supply fault detectors, logic input drivers and watchdog
`timescale 1ns/1ps
module sla_far_side (
  input  wire logic       clk,
  input  wire logic [6:0] supply_ok,
  input  wire logic [3:0] lin_lvl,
  input  wire logic       wd_lat,
  input  wire logic       wd_pul,
  output logic      [6:0] supply_fault,
  output logic      [3:0] general_logic_input,
  output logic            watchdog_latched,
  output logic            watchdog_pulsed
);
  // Comparators settle one cycle after the rail moves; the array resynchronises anyway
  always_ff @(posedge clk) begin
    supply_fault        <= ~supply_ok;
    general_logic_input <= lin_lvl;
    watchdog_latched    <= wd_lat;
    watchdog_pulsed     <= wd_pul;
  end
endmodule

// file: dv/tb.sv
// Self-checking testbench of the sequencing logic array
`timescale 1ns/1ps
module tb;
  logic       clk, rst, reg_wr_en, wd_lat, wd_pul;
  logic [6:0] supply_ok, supply_fault;
  logic [3:0] lin_lvl, general_logic_input;
  logic       watchdog_latched, watchdog_pulsed;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic [8:0] sequenced_output;
  int         n_fail, cmp_count, cycles;

  sla_far_side far (.clk(clk), .supply_ok(supply_ok), .lin_lvl(lin_lvl), .wd_lat(wd_lat),
    .wd_pul(wd_pul), .supply_fault(supply_fault), .general_logic_input(general_logic_input),
    .watchdog_latched(watchdog_latched), .watchdog_pulsed(watchdog_pulsed));
  sla_array dut (.clk(clk), .rst(rst), .supply_fault(supply_fault),
    .general_logic_input(general_logic_input), .watchdog_latched(watchdog_latched),
    .watchdog_pulsed(watchdog_pulsed), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .sequenced_output(sequenced_output));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en   <= 1'b0;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(posedge clk);
    #1;
    check({1'b0, reg_rd_data}, {1'b0, exp}, msg);
  endtask

  // Counts edges until the channel reaches v; fails if too early or never within hi
  task automatic wait_out(input int b, input logic v, input int lo, input int hi,
                          input string msg);
    int n;
    n = 0;
    while (sequenced_output[b] !== v && n < hi) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(9'(n >= lo && sequenced_output[b] === v), 9'h001, msg);
  endtask

  task automatic set_pins(input logic [6:0] ok, input logic [3:0] g);
    @(posedge clk);
    supply_ok <= ok;
    lin_lvl   <= g;
  endtask

  task automatic t_reset_values();
    check(sequenced_output, 9'h000, "outputs after reset");
    rd_check(8'h00, 8'h00, "peer invert A reset");
    rd_check(8'h01, 8'h00, "peer ignore A reset");
    rd_check(8'h8B, 8'h00, "cell 9 supply ignore B reset");
  endtask

  task automatic t_regs();
    wr(8'h00, 8'h5A);
    rd_check(8'h00, 8'h5A, "peer invert A write");
    wr(8'h00, 8'h00);
    wr(8'h0F, 8'hAA);
    rd_check(8'h0F, 8'h00, "unmapped byte");
    rd_check(8'h90, 8'h00, "cell beyond nine");
    wr(8'h10, 8'h3C);
    rd_check(8'h10, 8'h3C, "cell 2 peer invert A write");
    wr(8'h10, 8'h00);
  endtask

  // Cell 1 function A asserts only while every supply is within tolerance
  task automatic t_supply_good();
    wr(8'h01, 8'hFF);
    wr(8'h02, 8'h7F);
    wr(8'h04, 8'hF0);
    wr(8'h06, 8'h0A);
    check(sequenced_output, 9'h000, "no function enabled");
    wr(8'h07, 8'h01);
    wait_out(0, 1'b1, 0, 30, "all supplies good");
    rd_check(8'h0E, 8'h07, "status of cell 1");
    set_pins(7'h77, 4'h0);
    wait_out(0, 1'b0, 3, 30, "one supply faulty");
    set_pins(7'h7F, 4'h0);
    wait_out(0, 1'b1, 3, 30, "supply recovered");
  endtask

  // Function B alone follows general input 0; the other inputs are ignored
  task automatic t_func_b();
    wr(8'h07, 8'h00);
    wait_out(0, 1'b0, 0, 30, "A disabled");
    wr(8'h09, 8'hFF);
    wr(8'h0B, 8'h7F);
    wr(8'h05, 8'hE0);
    wr(8'h06, 8'hAA);
    wr(8'h07, 8'h02);
    repeat (8) @(posedge clk);
    wait_out(0, 1'b0, 0, 30, "B with input low");
    set_pins(7'h7F, 4'h1);
    wait_out(0, 1'b1, 3, 30, "B with input high");
    wr(8'h07, 8'h06);
    wait_out(0, 1'b0, 0, 30, "B output inverted");
    wr(8'h07, 8'h04);
    wait_out(0, 1'b1, 0, 30, "none enabled then inverted");
    wr(8'h07, 8'h03);
    set_pins(7'h7F, 4'h0);
    repeat (8) @(posedge clk);
    wait_out(0, 1'b1, 0, 30, "A holds while B low");
  endtask

  // Cell 2 follows the delayed output of cell 1, its first peer input
  task automatic t_peer();
    wr(8'h11, 8'hFE);
    wr(8'h13, 8'h7F);
    wr(8'h14, 8'hF0);
    wr(8'h16, 8'h0A);
    wr(8'h17, 8'h01);
    wait_out(1, 1'b1, 0, 30, "peer high");
    set_pins(7'h7E, 4'h0);
    wait_out(1, 1'b0, 3, 30, "peer low");
    check(sequenced_output, 9'h000, "both cells off");
  endtask

  // Rise delay of ten cycles postpones assertion; fall stays prompt
  task automatic t_delay();
    wr(8'h0C, 8'h0A);
    set_pins(7'h7F, 4'h0);
    wait_out(0, 1'b1, 14, 24, "delayed rise");
    set_pins(7'h7E, 4'h0);
    wait_out(0, 1'b0, 3, 10, "prompt fall");
  endtask

  // Cell 3 follows the latched watchdog output alone, with a rise delay of two cycles
  task automatic t_watchdog();
    wr(8'h21, 8'hFF);
    wr(8'h23, 8'h7F);
    wr(8'h24, 8'hF0);
    wr(8'h26, 8'h08);
    wr(8'h2C, 8'h02);
    wr(8'h27, 8'h01);
    repeat (4) @(posedge clk);
    #1;
    check(sequenced_output, 9'h000, "watchdog low keeps cell 3 off");
    @(posedge clk);
    wd_lat <= 1'b1;
    wait_out(2, 1'b1, 8, 12, "watchdog high after rise delay");
    wr(8'h26, 8'h09);
    wait_out(2, 1'b0, 2, 30, "watchdog inverted");
  endtask

  initial begin
    n_fail      = 0;
    cmp_count   = 0;
    cycles      = 0;
    rst         = 1'b1;
    reg_wr_en   = 1'b0;
    reg_addr    = 8'h00;
    reg_wr_data = 8'h00;
    supply_ok   = 7'h7F;
    lin_lvl     = 4'h0;
    wd_lat      = 1'b0;
    wd_pul      = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset_values();
    t_regs();
    t_supply_good();
    t_func_b();
    t_peer();
    t_delay();
    t_watchdog();
    final_report();
  end
endmodule
